// *** fer_defines.svh ***
// Constants for the fault event recorder
// Functional notes
// [RQ1] Start without trip stores peak pick-up current in main and sub.
// [RQ2] On trip, main holds trip-instant current, sub holds pick-up peak.
// [RQ3] Unbalance stores pick-up peak, or trip-instant value on trip.
// [RQ4] Each stage times its start as percent of set or curve time.
// [RQ5] Nonzero duration means started; a tripped stage records 100.
// [RQ6] Operate time elapsed while blocked records 99.
// [RQ7] Time stamp is taken when the last active stage drops off.
// [RQ8] Time stamp is a date word and a time-of-day word.
// [RQ9] Each of five stages has its own start counter up to 999.
// [RQ10] Five records; new one enters slot 0, oldest falls out.
// [RQ11] Collection starts on any start, commit after all drop off.
// [RQ12] Master reset clears records and counters.
// [RQ13] Start counters saturate at the limit.
`ifndef FER_DEFINES_SVH
`define FER_DEFINES_SVH
`define FER_STAGES 5
`define FER_CHANNELS 4
`define FER_SLOTS 5
`define FER_CUR_W 16
`define FER_PCT_W 7
`define FER_TIME_W 20
`define FER_CNT_W 10
`define FER_CNT_MAX 10'h3e7
`define FER_PCT_FULL 7'h64
`define FER_PCT_BLOCKED 7'h63
`define FER_DATE_W 16
`define FER_TOD_W 32
`endif

// *** fer_pkg.sv ***
// Types for the fault event recorder
`include "fer_defines.svh"
package fer_pkg;
    typedef struct packed {
        logic [`FER_CHANNELS-1:0][`FER_CUR_W-1:0] main_cur;
        logic [`FER_CHANNELS-1:0][`FER_CUR_W-1:0] sub_cur;
        logic [`FER_CUR_W-1:0] unbalance;
        logic [`FER_STAGES-1:0][`FER_PCT_W-1:0] duration;
        logic [`FER_DATE_W-1:0] date;
        logic [`FER_TOD_W-1:0] tod;
    } record_t;
    typedef enum logic [0:0] {IDLE, COLLECT} phase_t;
endpackage : fer_pkg

// *** stage_timer.sv ***
// One stage: start counter and start-duration measurement
`include "fer_defines.svh"
module stage_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Stage status
    input wire logic clear,
    input wire logic started,
    input wire logic tripped,
    input wire logic blocked,
    input wire logic [`FER_TIME_W-1:0] operate_time,
    // Results
    output logic [`FER_PCT_W-1:0] duration,
    output logic [`FER_CNT_W-1:0] start_count
);
    typedef struct packed {
        logic prev_start;
        logic [`FER_TIME_W-1:0] elapsed;
        logic [`FER_PCT_W-1:0] pct;
        logic [`FER_CNT_W-1:0] count;
    } timer_state_t;
    timer_state_t st, next_st;
    logic [`FER_TIME_W-1:0] run_el;
    logic [`FER_TIME_W+6:0] hundred_el;
    logic [`FER_PCT_W-1:0] ratio;
    logic [`FER_PCT_W-1:0] base_pct;

    ////////////////////////////////////////////////////////////////////
    // Cycles started so far, this one included, so the ratio has no lag
    // Ratio by compare; a divider would be too costly per stage
    always_comb begin
        if (!st.prev_start) begin
            run_el = 20'h00001;
        end else if (st.elapsed != {`FER_TIME_W{1'b1}}) begin
            run_el = st.elapsed + 20'h00001;
        end else begin
            run_el = st.elapsed;
        end
        hundred_el = {7'h00, run_el} * 27'h0000064;
        ratio = `FER_PCT_BLOCKED;
        for (int i = 98; i >= 0; i--) begin
            if (hundred_el < {7'h00, operate_time} * 27'(i + 1)) begin
                ratio = 7'(i);
            end
        end
    end

    // A fresh event starts from zero, so no stale value of the last one
    always_comb begin
        next_st = st;
        next_st.prev_start = started;
        base_pct = clear ? 7'h00 : st.pct; // [RQ11]
        next_st.pct = base_pct;
        if (clear) begin
            next_st.elapsed = '0;
        end
        if (started) begin
            next_st.elapsed = run_el; // [RQ4]
            if (!st.prev_start && st.count != `FER_CNT_MAX) begin
                next_st.count = st.count + 10'h001; // [RQ9] [RQ13]
            end
            // Never zero once started, so zero still means no start
            if (tripped) begin
                next_st.pct = `FER_PCT_FULL; // [RQ5]
            end else if (base_pct != `FER_PCT_FULL) begin
                if (run_el >= operate_time && blocked) begin
                    next_st.pct = `FER_PCT_BLOCKED; // [RQ6]
                end else if (ratio > base_pct) begin
                    next_st.pct = ratio; // [RQ4]
                end else if (base_pct == 7'h00) begin
                    next_st.pct = 7'h01; // [RQ5]
                end
            end
        end else if (tripped) begin
            next_st.pct = `FER_PCT_FULL;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0; // [RQ12]
        end else begin
            st <= next_st;
        end
    end

    assign duration = st.pct;
    assign start_count = st.count;
endmodule : stage_timer

// *** fault_event_recorder.sv ***
// Fault event recorder: collects one event and keeps the last five
`include "fer_defines.svh"
module fault_event_recorder (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Protection stage status
    input wire logic [`FER_STAGES-1:0] stage_start,
    input wire logic [`FER_STAGES-1:0] stage_trip,
    input wire logic [`FER_STAGES-1:0] stage_blocked,
    input wire logic [`FER_STAGES-1:0][`FER_TIME_W-1:0] operate_time,
    input wire logic [`FER_STAGES-1:0] inverse_time_curve,
    input wire logic [`FER_STAGES-1:0][`FER_TIME_W-1:0] curve_time,
    // Measurements
    input wire logic [`FER_CHANNELS-1:0][`FER_CUR_W-1:0] current,
    input wire logic [`FER_CUR_W-1:0] unbalance,
    // Real-time clock
    input wire logic [`FER_DATE_W-1:0] rtc_date,
    input wire logic [`FER_TOD_W-1:0] rtc_tod,
    // Stored records and counters
    output fer_pkg::record_t [`FER_SLOTS-1:0] records,
    output logic [`FER_STAGES-1:0][`FER_CNT_W-1:0] start_count,
    output logic event_stored
);
    typedef struct packed {
        fer_pkg::phase_t phase;
        logic tripped_any;
        logic [`FER_STAGES-1:0] trip_prev;
        fer_pkg::record_t work;
        fer_pkg::record_t [`FER_SLOTS-1:0] slots;
        logic stored;
    } rec_state_t;
    rec_state_t st, next_st;
    logic any_start;
    logic trip_edge;
    logic clear_work;
    logic [`FER_STAGES-1:0][`FER_PCT_W-1:0] duration;
    logic [`FER_STAGES-1:0][`FER_TIME_W-1:0] eff_time;

    ////////////////////////////////////////////////////////////////////
    // Stage timers, one per stage
    assign clear_work = (st.phase == fer_pkg::IDLE) && any_start;
    for (genvar g = 0; g < `FER_STAGES; g++) begin : g_stage
        assign eff_time[g] = inverse_time_curve[g] ? curve_time[g]
                                                   : operate_time[g]; // [RQ4]
        stage_timer u_timer (
            .clk(clk),
            .arst_n(arst_n),
            .clear(clear_work),
            .started(stage_start[g]),
            .tripped(stage_trip[g]),
            .blocked(stage_blocked[g]),
            .operate_time(eff_time[g]),
            .duration(duration[g]),
            .start_count(start_count[g])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // Event collection and record shifting
    assign any_start = |stage_start;
    assign trip_edge = |(stage_trip & ~st.trip_prev);

    always_comb begin
        next_st = st;
        next_st.stored = 1'b0;
        next_st.trip_prev = stage_trip;
        case (st.phase)
            fer_pkg::IDLE: begin
                if (any_start) begin
                    next_st.phase = fer_pkg::COLLECT; // [RQ11]
                    // A trip on the opening edge freezes main at once
                    next_st.tripped_any = trip_edge; // [RQ2]
                    next_st.work = '0;
                    next_st.work.main_cur = current;
                    next_st.work.sub_cur = current;
                    next_st.work.unbalance = unbalance;
                end
            end
            fer_pkg::COLLECT: begin
                // Sub peaks track the whole event; main and unbalance peaks only until the first trip
                for (int c = 0; c < `FER_CHANNELS; c++) begin
                    if (current[c] > st.work.sub_cur[c]) begin
                        next_st.work.sub_cur[c] = current[c]; // [RQ1]
                        if (!st.tripped_any) begin
                            next_st.work.main_cur[c] = current[c]; // [RQ1]
                        end
                    end
                end
                if (!st.tripped_any && unbalance > st.work.unbalance) begin
                    next_st.work.unbalance = unbalance; // [RQ3]
                end
                if (trip_edge && !st.tripped_any) begin
                    next_st.tripped_any = 1'b1;
                    next_st.work.main_cur = current; // [RQ2]
                    next_st.work.unbalance = unbalance; // [RQ3]
                end
                if (!any_start && !(|stage_trip)) begin
                    // Commit only when every stage has dropped off
                    next_st.phase = fer_pkg::IDLE; // [RQ11]
                    next_st.work.duration = duration;
                    next_st.work.date = rtc_date; // [RQ7] [RQ8]
                    next_st.work.tod = rtc_tod; // [RQ7] [RQ8]
                    for (int s = `FER_SLOTS - 1; s > 0; s--) begin
                        next_st.slots[s] = st.slots[s-1]; // [RQ10]
                    end
                    next_st.slots[0] = next_st.work; // [RQ10]
                    next_st.stored = 1'b1;
                end
            end
            default: begin
                next_st.phase = fer_pkg::IDLE;
            end
        endcase
    end

    // Power-loss retention is left to the storage outside this block
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0; // [RQ12]
        end else begin
            st <= next_st;
        end
    end

    assign records = st.slots;
    assign event_stored = st.stored;
endmodule : fault_event_recorder

// *** fer_properties.sv ***
// Port checker for the fault event recorder
`include "fer_defines.svh"
module fer_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Watched ports
    input wire logic [4:0] stage_start,
    input wire logic [4:0] stage_trip,
    input wire logic [15:0] rtc_date,
    input wire logic [31:0] rtc_tod,
    input wire fer_pkg::record_t [4:0] records,
    input wire logic [4:0][9:0] start_count,
    input wire logic event_stored
);
    timeunit 1ns;
    timeprecision 100ps;
    /////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // A stage held, then every stage quiet: the event must close
    sequence busy_then_quiet;
        |stage_start ##1 (stage_start == 5'h00 && stage_trip == 5'h00);
    endsequence
    // Commit pulse and its cause
    pulse_once_a: assert property (event_stored |=> !event_stored)
        else $error("commit pulse too long");
    commit_after_drop_a: assert property (
        busy_then_quiet |=> event_stored) else $error("no commit after drop");
    no_early_commit_a: assert property (event_stored |->
        $past(stage_start) == 5'h00) else $error("commit while started");
    // Slots move only on a commit
    slot_shift_a: assert property (event_stored |->
        records[4:1] == $past(records[3:0])) else $error("bad shift");
    records_hold_a: assert property (!event_stored |->
        $stable(records)) else $error("records moved");
    // The stamp is the clock seen on the drop-off edge
    stamp_at_drop_a: assert property (event_stored |->
        records[0].tod == $past(rtc_tod)) else $error("bad time stamp");
    date_stamp_a: assert property (event_stored |->
        records[0].date == $past(rtc_date)) else $error("bad date stamp");
    sub_peak_a: assert property (event_stored |->
        records[0].sub_cur[0] >= records[0].main_cur[0]) else $error("sub");
    // Counter steps once per start and stops at its limit
    count_step_a: assert property ($rose(stage_start[4]) |=>
        start_count[4] == ($past(start_count[4]) == `FER_CNT_MAX ?
        `FER_CNT_MAX : $past(start_count[4]) + 10'h001))
        else $error("bad count step");
    count_cap_a: assert property (start_count[4] <= `FER_CNT_MAX)
        else $error("count over limit");
    reset_clear_a: assert property ($rose(arst_n) |->
        records == '0 && start_count == '0) else $error("not cleared");
endmodule : fer_properties
bind fault_event_recorder fer_properties u_fer_properties (.*);

// *** fer_front_model.sv ***
// Stand-in for the stage logic and measurement front end
module fer_front_model (
    // Clock
    input wire logic clk,
    // Requests from the bench
    input wire logic [4:0] req_start,
    input wire logic [4:0] req_trip,
    input wire logic [15:0] req_cur,
    // Stage status and samples
    output logic [4:0] stage_start,
    output logic [4:0] stage_trip,
    output logic [3:0][15:0] current,
    output logic [15:0] unbalance
);
    timeunit 1ns;
    timeprecision 100ps;
    /////////////////////////////////////////////////////////
    // A stage trips only while started; channels differ by index
    always_ff @(posedge clk) begin
        stage_start <= req_start;
        stage_trip <= req_trip & req_start;
        unbalance <= req_cur;
        for (int k = 0; k < 4; k++) current[k] <= req_cur + 16'(k);
    end
endmodule : fer_front_model

// *** fault_event_recorder_tb.sv ***
// Bench for the fault event recorder
module fault_event_recorder_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'h0;
    logic arst_n = 1'h0;
    logic cmt;
    logic [4:0] rs = 5'h0, rt = 5'h0, blk = 5'h0, inv = 5'h0, st, tr;
    logic [15:0] cur = 16'h0, ub;
    logic [15:0] day = 16'h2401;
    logic [3:0][15:0] ci;
    logic [31:0] tod = 32'h0;
    fer_pkg::record_t [4:0] rec;
    logic [4:0][9:0] cnt;
    int err_total = 0;
    int total_checks = 0;
    /////////////////////////////////////////////////////////
    // Clock; time of day counts cycles so stamps differ
    always #12.5 clk = ~clk;
    always @(posedge clk) tod <= tod + 32'h1;
    fer_front_model u_fer_front_model (.clk(clk), .req_start(rs),
        .req_trip(rt), .req_cur(cur), .stage_start(st), .stage_trip(tr),
        .current(ci), .unbalance(ub));
    fault_event_recorder u_fault_event_recorder (.clk(clk),
        .arst_n(arst_n), .stage_start(st), .stage_trip(tr),
        .stage_blocked(blk), .operate_time({5{20'h00064}}),
        .inverse_time_curve(inv), .curve_time({5{20'h00004}}),
        .current(ci), .unbalance(ub), .rtc_date(day), .rtc_tod(tod),
        .records(rec), .start_count(cnt), .event_stored(cmt));
    /////////////////////////////////////////////////////////
    task chk(input string n, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s exp %0h got %0h", n, e, g);
        end
    endtask : chk
    task results;
        if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    // One cycle of stage state
    task step(input logic [4:0] s, t, input logic [15:0] c);
        rs <= s;
        rt <= t;
        cur <= c;
        @(posedge clk);
    endtask : step
    // Drop every stage, wait bounded for the commit pulse
    task drop;
        int i;
        step(5'h0, 5'h0, 16'h0);
        for (i = 0; i < 20 && cmt !== 1'b1; i++) @(negedge clk);
        if (cmt !== 1'b1) begin
            err_total++;
            results();
        end
        @(posedge clk);
    endtask : drop
    // Three started cycles of a 100-cycle operate time give 3 percent
    task t_pickup;
        day <= 16'h2402;
        step(5'h01, 5'h0, 16'h0010);
        step(5'h01, 5'h0, 16'h0030);
        step(5'h01, 5'h0, 16'h0020);
        drop();
        chk("main3", 16'h0033, rec[0].main_cur[3]);
        chk("sub3", 16'h0033, rec[0].sub_cur[3]);
        chk("sub0", 16'h0030, rec[0].sub_cur[0]);
        chk("unbal", 16'h0030, rec[0].unbalance);
        chk("dur0", 7'h03, rec[0].duration[0]);
        chk("cnt0", 1, cnt[0]);
        chk("date", 16'h2402, rec[0].date);
    endtask : t_pickup
    task t_trip;
        step(5'h02, 5'h0, 16'h0040);
        step(5'h02, 5'h02, 16'h0025);
        step(5'h02, 5'h02, 16'h0050);
        drop();
        chk("main1", 16'h0026, rec[0].main_cur[1]);
        chk("sub1", 16'h0051, rec[0].sub_cur[1]);
        chk("unbal", 16'h0025, rec[0].unbalance);
        chk("dur1", 7'h64, rec[0].duration[1]);
        chk("old", 16'h0030, rec[1].main_cur[0]);
    endtask : t_trip
    // Curve time is short, so the blocked stage runs out
    task t_blocked;
        blk <= 5'h04;
        inv <= 5'h04;
        repeat (8) step(5'h04, 5'h0, 16'h0008);
        drop();
        chk("dur2", 7'h63, rec[0].duration[2]);
        blk <= 5'h0;
        inv <= 5'h0;
    endtask : t_blocked
    task t_shift;
        repeat (3) begin
            step(5'h08, 5'h0, 16'h0001);
            drop();
        end
        chk("slot4", 16'h0026, rec[4].main_cur[1]);
        chk("cnt3", 3, cnt[3]);
    endtask : t_shift
    // Start and trip on the same edge: main holds that first sample
    task t_early_trip;
        step(5'h01, 5'h01, 16'h0060);
        step(5'h01, 5'h01, 16'h0070);
        drop();
        chk("main0t", 16'h0060, rec[0].main_cur[0]);
        chk("sub0t", 16'h0070, rec[0].sub_cur[0]);
        chk("unbalt", 16'h0060, rec[0].unbalance);
        chk("dur0t", 7'h64, rec[0].duration[0]);
    endtask : t_early_trip
    task t_saturate;
        repeat (1001) begin
            step(5'h10, 5'h0, 16'h0002);
            drop();
        end
        chk("cnt4", 10'h3e7, cnt[4]);
    endtask : t_saturate
    task t_reset;
        arst_n <= 1'h0;
        repeat (2) @(posedge clk);
        arst_n <= 1'h1;
        @(negedge clk);
        chk("clear", 1, rec === '0 && cnt === '0);
        // One event after release: counting restarts from zero
        @(posedge clk);
        step(5'h01, 5'h0, 16'h0005);
        drop();
        chk("cnt0r", 1, cnt[0]);
        chk("slot1", 1, rec[1] === '0);
    endtask : t_reset
    /////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'h1;
        @(posedge clk);
        t_pickup();
        t_trip();
        t_blocked();
        t_shift();
        t_early_trip();
        t_saturate();
        t_reset();
        results();
    end
endmodule : fault_event_recorder_tb
